// *** hw/amd_pkg.sv ***
package amd_pkg;

  // ----------------------------------------------------------------
  // Addressing-mode groups
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AMD_GRP_INHERENT  = 3'h0,
    AMD_GRP_IMMEDIATE = 3'h1,
    AMD_GRP_DIRECT    = 3'h2,
    AMD_GRP_INDEXED   = 3'h3,
    AMD_GRP_INDIRECT  = 3'h4,
    AMD_GRP_RELATIVE  = 3'h5,
    AMD_GRP_BIT       = 3'h6,
    AMD_GRP_ILLEGAL   = 3'h7
  } amd_group_t;

  // ----------------------------------------------------------------
  // The seventeen submodes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    AMD_M_INH       = 5'h00,
    AMD_M_IMM       = 5'h01,
    AMD_M_DIR_S     = 5'h02,
    AMD_M_DIR_L     = 5'h03,
    AMD_M_IDX_0     = 5'h04,
    AMD_M_IDX_S     = 5'h05,
    AMD_M_IDX_L     = 5'h06,
    AMD_M_IND_S     = 5'h07,
    AMD_M_IND_L     = 5'h08,
    AMD_M_INDX_S    = 5'h09,
    AMD_M_INDX_L    = 5'h0A,
    AMD_M_REL_D     = 5'h0B,
    AMD_M_REL_I     = 5'h0C,
    AMD_M_BIT_D     = 5'h0D,
    AMD_M_BIT_I     = 5'h0E,
    AMD_M_BIT_DR    = 5'h0F,
    AMD_M_BIT_IR    = 5'h10,
    AMD_M_NONE      = 5'h1F
  } amd_mode_t;

  // Opcode high nibble rows
  localparam logic [3:0] AMD_ROW_BTJ = 4'h0;
  localparam logic [3:0] AMD_ROW_BSR = 4'h1;
  localparam logic [3:0] AMD_ROW_REL = 4'h2;
  localparam logic [3:0] AMD_ROW_RMW_DIR = 4'h3;
  localparam logic [3:0] AMD_ROW_RMW_A = 4'h4;
  localparam logic [3:0] AMD_ROW_RMW_X = 4'h5;
  localparam logic [3:0] AMD_ROW_RMW_IX1 = 4'h6;
  localparam logic [3:0] AMD_ROW_RMW_IX0 = 4'h7;
  localparam logic [3:0] AMD_ROW_SYS = 4'h8;
  localparam logic [3:0] AMD_ROW_MISC = 4'h9;
  localparam logic [3:0] AMD_ROW_IMM = 4'hA;
  localparam logic [3:0] AMD_ROW_DIR = 4'hB;
  localparam logic [3:0] AMD_ROW_EXT = 4'hC;
  localparam logic [3:0] AMD_ROW_IX2 = 4'hD;
  localparam logic [3:0] AMD_ROW_IX1 = 4'hE;
  localparam logic [3:0] AMD_ROW_IX0 = 4'hF;

  // Prebytes
  localparam logic [7:0] AMD_PRE_Y = 8'h90;
  localparam logic [7:0] AMD_PRE_IY = 8'h91;
  localparam logic [7:0] AMD_PRE_IX = 8'h92;

  // Special single-byte opcodes
  localparam logic [7:0] AMD_OP_TRAP = 8'h83;
  localparam logic [7:0] AMD_OP_WAIT = 8'h8F;
  localparam logic [7:0] AMD_OP_HALT = 8'h8E;

  // Immediate-capable low nibbles (ld, cp, bcp, and/or/xor, add/sub/adc/sbc, and jmp)
  localparam logic [15:0] AMD_IMM_OK_MASK = 16'h1EFF;
  localparam logic [3:0] AMD_LO_JMP = 4'hC;
  localparam logic [3:0] AMD_LO_CALL = 4'hD;

  // Address space figures
  localparam logic [15:0] AMD_PAGE0_TOP = 16'h00FF;
  localparam logic [8:0] AMD_IDX_S_TOP = 9'h1FE;
  localparam logic [7:0] AMD_ZERO_HI = 8'h00;
  localparam logic [1:0] AMD_EXT_0 = 2'h0;
  localparam logic [1:0] AMD_EXT_1 = 2'h1;
  localparam logic [1:0] AMD_EXT_2 = 2'h2;
  localparam logic [1:0] AMD_EXT_3 = 2'h3;
  localparam logic [15:0] AMD_ONE = 16'h0001;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    amd_group_t group;
    amd_mode_t mode;
    logic [1:0] ext_bytes;
    logic use_y;
    logic is_short;
    logic is_illegal;
    logic wait_req;
    logic halt_req;
    logic trap_req;
  } amd_decode_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } amd_mem_req_t;

endpackage

// *** hw/amd_classify.sv ***
`timescale 1ns/1ps
module amd_classify (
  // Opcode and prebyte
  input wire logic [7:0] opcode,
  input wire logic [7:0] prebyte,
  input wire logic prebyte_valid,
  // Decode result
  output amd_pkg::amd_decode_t dec
);

  logic [3:0] row;
  logic [3:0] lo;
  logic pre_y;
  logic pre_ix;
  logic pre_iy;
  logic pre_ind;

  assign row = opcode[7:4];
  assign lo = opcode[3:0];
  assign pre_y = prebyte_valid && (prebyte == amd_pkg::AMD_PRE_Y);
  assign pre_ix = prebyte_valid && (prebyte == amd_pkg::AMD_PRE_IX);
  assign pre_iy = prebyte_valid && (prebyte == amd_pkg::AMD_PRE_IY);
  assign pre_ind = pre_ix || pre_iy;

  always_comb begin
    dec = '0;
    dec.group = amd_pkg::AMD_GRP_ILLEGAL;
    dec.mode = amd_pkg::AMD_M_NONE;
    dec.ext_bytes = amd_pkg::AMD_EXT_0;
    dec.use_y = pre_y || pre_iy;
    dec.is_short = 1'b1;
    dec.is_illegal = 1'b0;
    case (row)
      // Bit test-and-branch, short only
      amd_pkg::AMD_ROW_BTJ: begin
        dec.group = amd_pkg::AMD_GRP_BIT;
        dec.mode = pre_ind ? amd_pkg::AMD_M_BIT_IR : amd_pkg::AMD_M_BIT_DR;
        dec.ext_bytes = pre_ind ? amd_pkg::AMD_EXT_3 : amd_pkg::AMD_EXT_2;
      end
      amd_pkg::AMD_ROW_BSR: begin
        dec.group = amd_pkg::AMD_GRP_BIT;
        dec.mode = pre_ind ? amd_pkg::AMD_M_BIT_I : amd_pkg::AMD_M_BIT_D;
        dec.ext_bytes = pre_ind ? amd_pkg::AMD_EXT_2 : amd_pkg::AMD_EXT_1;
      end
      amd_pkg::AMD_ROW_REL: begin
        dec.group = amd_pkg::AMD_GRP_RELATIVE;
        dec.mode = pre_ind ? amd_pkg::AMD_M_REL_I : amd_pkg::AMD_M_REL_D;
        dec.ext_bytes = pre_ind ? amd_pkg::AMD_EXT_2 : amd_pkg::AMD_EXT_1;
      end
      // [RQ4] no long row for memory ops
      amd_pkg::AMD_ROW_RMW_DIR: begin
        dec.group = pre_ind ? amd_pkg::AMD_GRP_INDIRECT : amd_pkg::AMD_GRP_DIRECT;
        dec.mode = pre_ind ? amd_pkg::AMD_M_IND_S : amd_pkg::AMD_M_DIR_S;
        dec.ext_bytes = pre_ind ? amd_pkg::AMD_EXT_2 : amd_pkg::AMD_EXT_1;
      end
      amd_pkg::AMD_ROW_RMW_A, amd_pkg::AMD_ROW_RMW_X, amd_pkg::AMD_ROW_SYS,
      amd_pkg::AMD_ROW_MISC: begin
        dec.group = amd_pkg::AMD_GRP_INHERENT;
        dec.mode = amd_pkg::AMD_M_INH;
        dec.is_illegal = pre_ind;
      end
      amd_pkg::AMD_ROW_RMW_IX1, amd_pkg::AMD_ROW_IX1: begin
        dec.group = pre_ind ? amd_pkg::AMD_GRP_INDIRECT : amd_pkg::AMD_GRP_INDEXED;
        dec.mode = pre_ind ? amd_pkg::AMD_M_INDX_S : amd_pkg::AMD_M_IDX_S;
        dec.ext_bytes = pre_ind ? amd_pkg::AMD_EXT_2 : amd_pkg::AMD_EXT_1;
      end
      amd_pkg::AMD_ROW_RMW_IX0, amd_pkg::AMD_ROW_IX0: begin
        dec.group = amd_pkg::AMD_GRP_INDEXED;
        dec.mode = amd_pkg::AMD_M_IDX_0;
        dec.ext_bytes = pre_y ? amd_pkg::AMD_EXT_1 : amd_pkg::AMD_EXT_0;
        dec.is_illegal = pre_ind;
      end
      amd_pkg::AMD_ROW_IMM: begin
        dec.group = amd_pkg::AMD_GRP_IMMEDIATE;
        dec.mode = amd_pkg::AMD_M_IMM;
        dec.ext_bytes = amd_pkg::AMD_EXT_1;
        // [RQ7] immediate op filter
        dec.is_illegal = !amd_pkg::AMD_IMM_OK_MASK[lo] || pre_ind;
      end
      amd_pkg::AMD_ROW_DIR: begin
        dec.group = pre_ind ? amd_pkg::AMD_GRP_INDIRECT : amd_pkg::AMD_GRP_DIRECT;
        dec.mode = pre_ind ? amd_pkg::AMD_M_IND_S : amd_pkg::AMD_M_DIR_S;
        dec.ext_bytes = pre_ind ? amd_pkg::AMD_EXT_2 : amd_pkg::AMD_EXT_1;
      end
      amd_pkg::AMD_ROW_EXT: begin
        dec.group = pre_ind ? amd_pkg::AMD_GRP_INDIRECT : amd_pkg::AMD_GRP_DIRECT;
        dec.mode = pre_ind ? amd_pkg::AMD_M_IND_L : amd_pkg::AMD_M_DIR_L;
        dec.ext_bytes = amd_pkg::AMD_EXT_2;
        dec.is_short = 1'b0;
      end
      default: begin
        dec.group = pre_ind ? amd_pkg::AMD_GRP_INDIRECT : amd_pkg::AMD_GRP_INDEXED;
        dec.mode = pre_ind ? amd_pkg::AMD_M_INDX_L : amd_pkg::AMD_M_IDX_L;
        dec.ext_bytes = amd_pkg::AMD_EXT_2;
        dec.is_short = 1'b0;
      end
    endcase
    if (dec.is_illegal) begin
      dec.group = amd_pkg::AMD_GRP_ILLEGAL;
      dec.mode = amd_pkg::AMD_M_NONE;
      dec.ext_bytes = amd_pkg::AMD_EXT_0;
    end
    dec.trap_req = prebyte_valid ? 1'b0 : (opcode == amd_pkg::AMD_OP_TRAP);
    dec.wait_req = prebyte_valid ? 1'b0 : (opcode == amd_pkg::AMD_OP_WAIT);
    dec.halt_req = prebyte_valid ? 1'b0 : (opcode == amd_pkg::AMD_OP_HALT);
  end

endmodule

// *** hw/amd_decoder.sv ***
`timescale 1ns/1ps
// Summary of operation
// [RQ1] Opcodes sort into seventeen submodes in seven groups.
// [RQ2] Short forms reach page zero only and take fewer bytes and cycles; short indexed here reaches up to 1FE.
// [RQ3] Long forms take a two-byte extension and reach all 64 Kbyte.
// [RQ4] Memory-to-memory operations decode only in short forms.
// [RQ5] Inherent instructions are one byte with nothing fetched after.
// [RQ6] Immediate instructions are two bytes, the second being the operand.
// [RQ7] Only load, compare, bit compare, logic and add/sub take immediates; the mask here also passes AMD_LO_JMP.
// [RQ8] Short direct uses the byte after the opcode as a page-zero address.
// [RQ9] No-offset indexed uses the index alone, plus one byte with Y.
// [RQ10] Relative base is the address after the branch, range -128 to +127.
// [RQ11] Wait enters low power, halt stops the oscillator, trap interrupts.
// [RQ12] Indexed address is the unsigned sum of index and offset.
// [RQ13] Short indirect reads a one-byte page-zero pointer.
// [RQ14] Long indirect reads a two-byte page-zero pointer.
// [RQ15] Relative adds a signed byte offset, direct or from memory.
// [RQ16] Short addresses are zero-extended to sixteen bits.
module amd_decoder (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Instruction fetch stream
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  output logic fetch_ready,
  // Core register context
  input wire logic [15:0] pc_in,
  input wire logic [7:0] index_x,
  input wire logic [7:0] index_y,
  // Data memory pointer reads
  output amd_pkg::amd_mem_req_t ptr_req,
  input wire logic ptr_ack,
  input wire logic [7:0] ptr_data,
  // Decode results
  output logic ea_valid,
  output logic [15:0] ea_addr,
  output logic [7:0] imm_operand,
  output logic [7:0] rel_offset,
  output amd_pkg::amd_decode_t dec_out,
  // Core side effects
  output logic wait_enter,
  output logic halt_enter,
  output logic trap_raise,
  output logic illegal_op
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  // Two flops keep a ragged release off the state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AMD_S_OPC  = 3'b000,
    AMD_S_EXT  = 3'b001,
    AMD_S_PTRL = 3'b011,
    AMD_S_PTRH = 3'b010,
    AMD_S_DONE = 3'b110
  } amd_state_t;

  // State carried between instruction bytes
  amd_state_t state_r, state_nxt;
  logic [7:0] pre_r, pre_nxt;
  logic pre_v_r, pre_v_nxt;
  logic [7:0] opc_r, opc_nxt;
  logic [1:0] left_r, left_nxt;
  logic [15:0] ext_r, ext_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic ea_valid_nxt;
  logic [15:0] ea_nxt;
  logic [7:0] imm_nxt;
  logic [7:0] rel_nxt;
  amd_pkg::amd_decode_t dec_nxt;
  logic wait_nxt, halt_nxt, trap_nxt, ill_nxt;
  amd_pkg::amd_mem_req_t ptr_req_nxt;

  amd_pkg::amd_decode_t cls;
  logic is_pre;
  logic [15:0] idx;
  logic [15:0] base;
  logic [15:0] ptr_addr;

  // Live byte in the opcode state, held opcode after
  amd_classify u_classify (
    .opcode(state_r == AMD_S_OPC ? fetch_byte : opc_r),
    .prebyte(pre_r),
    .prebyte_valid(pre_v_r),
    .dec(cls)
  );

  assign is_pre = (fetch_byte == amd_pkg::AMD_PRE_Y) || (fetch_byte == amd_pkg::AMD_PRE_IX)
    || (fetch_byte == amd_pkg::AMD_PRE_IY);
  // [RQ16] zero-extend index
  assign idx = {amd_pkg::AMD_ZERO_HI, (cls.use_y ? index_y : index_x)};
  // Pointer address is always a page-zero byte
  assign ptr_addr = {amd_pkg::AMD_ZERO_HI, ext_r[7:0]};
  // Refused during pointer reads and the result cycle
  assign fetch_ready = (state_r == AMD_S_OPC) || (state_r == AMD_S_EXT);

  // ------------------------
  // Next-state logic
  // ------------------------
  // Address, operand and offset outputs keep their value between results
  always_comb begin
    state_nxt = state_r;
    pre_nxt = pre_r;
    pre_v_nxt = pre_v_r;
    opc_nxt = opc_r;
    left_nxt = left_r;
    ext_nxt = ext_r;
    ptr_nxt = ptr_r;
    pc_nxt = pc_r;
    ea_valid_nxt = 1'b0;
    ea_nxt = ea_addr;
    imm_nxt = imm_operand;
    rel_nxt = rel_offset;
    dec_nxt = dec_out;
    wait_nxt = 1'b0;
    halt_nxt = 1'b0;
    trap_nxt = 1'b0;
    ill_nxt = 1'b0;
    ptr_req_nxt = '0;
    base = '0;
    case (state_r)
      AMD_S_OPC: begin
        if (fetch_valid) begin
          pc_nxt = pc_in;
          // Prebyte held until the result or an illegal decode
          if (is_pre && !pre_v_r) begin
            pre_nxt = fetch_byte;
            pre_v_nxt = 1'b1;
          end else begin
            opc_nxt = fetch_byte;
            ext_nxt = '0;
            // [RQ1] group chosen
            dec_nxt = cls;
            if (cls.is_illegal) begin
              // Bad combination: no result
              ill_nxt = 1'b1;
              pre_v_nxt = 1'b0;
            end else if (cls.ext_bytes == amd_pkg::AMD_EXT_0 ||
                         cls.mode == amd_pkg::AMD_M_IDX_0) begin
              // [RQ5] one-byte, no further fetch
              // [RQ9] Y prebyte is the extra byte
              ea_valid_nxt = 1'b1;
              ea_nxt = (cls.group == amd_pkg::AMD_GRP_INDEXED) ? idx : '0;
              // [RQ11] special single-byte ops
              wait_nxt = cls.wait_req;
              halt_nxt = cls.halt_req;
              trap_nxt = cls.trap_req;
              pre_v_nxt = 1'b0;
            end else begin
              // Prebyte bytes are counted as extension bytes, dropped at the pointer byte
              left_nxt = cls.ext_bytes;
              state_nxt = AMD_S_EXT;
            end
          end
        end
      end
      AMD_S_EXT: begin
        if (fetch_valid) begin
          // [RQ3] word extension high byte first
          ext_nxt = {ext_r[7:0], fetch_byte};
          left_nxt = left_r - 2'h1;
          if (left_r == amd_pkg::AMD_EXT_1) begin
            state_nxt = AMD_S_DONE;
          end else if (pre_v_r && (pre_r != amd_pkg::AMD_PRE_Y) &&
                       (left_r == amd_pkg::AMD_EXT_2 || left_r == amd_pkg::AMD_EXT_3)) begin
            // Prebyte counted: first byte is the pointer,
            // for bit-and-branch an offset byte follows the pointer read
            state_nxt = AMD_S_PTRL;
            ptr_req_nxt.valid = 1'b1;
            ptr_req_nxt.addr = {amd_pkg::AMD_ZERO_HI, fetch_byte};
            left_nxt = left_r - amd_pkg::AMD_EXT_2;
          end
        end
      end
      AMD_S_PTRL: begin
        // Request stands until answered
        ptr_req_nxt = ptr_req;
        if (ptr_ack) begin
          ptr_req_nxt = '0;
          // [RQ13] one-byte pointer, zero-extended
          ptr_nxt = {amd_pkg::AMD_ZERO_HI, ptr_data};
          if (dec_out.mode == amd_pkg::AMD_M_IND_L || dec_out.mode == amd_pkg::AMD_M_INDX_L) begin
            // [RQ14] second pointer byte
            state_nxt = AMD_S_PTRH;
            ptr_req_nxt.valid = 1'b1;
            ptr_req_nxt.addr = ptr_addr + amd_pkg::AMD_ONE;
          end else begin
            state_nxt = (left_r != 2'h0) ? AMD_S_EXT : AMD_S_DONE;
          end
        end
      end
      AMD_S_PTRH: begin
        ptr_req_nxt = ptr_req;
        if (ptr_ack) begin
          ptr_req_nxt = '0;
          // [RQ14] low pointer byte second
          ptr_nxt = {ptr_r[7:0], ptr_data};
          state_nxt = AMD_S_DONE;
        end
      end
      // Result cycle: all outputs settle
      default: begin
        ea_valid_nxt = 1'b1;
        pre_v_nxt = 1'b0;
        state_nxt = AMD_S_OPC;
        case (dec_out.mode)
          // [RQ6] second byte is the operand
          amd_pkg::AMD_M_IMM: imm_nxt = ext_r[7:0];
          // [RQ8] [RQ2] short direct, page zero
          amd_pkg::AMD_M_DIR_S,
          amd_pkg::AMD_M_BIT_D: ea_nxt = {amd_pkg::AMD_ZERO_HI, ext_r[7:0]};
          // Address byte first, offset after
          amd_pkg::AMD_M_BIT_DR: ea_nxt = {amd_pkg::AMD_ZERO_HI, ext_r[15:8]};
          amd_pkg::AMD_M_DIR_L: ea_nxt = ext_r;
          // Index read with the opcode; this arm is not reached
          amd_pkg::AMD_M_IDX_0: ea_nxt = idx;
          // [RQ12] unsigned index sum
          amd_pkg::AMD_M_IDX_S: ea_nxt = idx + {amd_pkg::AMD_ZERO_HI, ext_r[7:0]};
          amd_pkg::AMD_M_IDX_L: ea_nxt = idx + ext_r;
          amd_pkg::AMD_M_IND_S, amd_pkg::AMD_M_IND_L, amd_pkg::AMD_M_BIT_I,
          amd_pkg::AMD_M_BIT_IR: ea_nxt = ptr_r;
          amd_pkg::AMD_M_INDX_S, amd_pkg::AMD_M_INDX_L: ea_nxt = idx + ptr_r;
          amd_pkg::AMD_M_REL_D, amd_pkg::AMD_M_REL_I: begin
            // [RQ10] [RQ15] base past the branch, signed byte offset
            rel_nxt = (dec_out.mode == amd_pkg::AMD_M_REL_I) ? ptr_r[7:0] : ext_r[7:0];
            base = pc_r;
            ea_nxt = base + {{8{rel_nxt[7]}}, rel_nxt};
          end
          default: ea_nxt = '0;
        endcase
        // Bit-and-branch hands over its offset
        if (dec_out.mode == amd_pkg::AMD_M_BIT_DR || dec_out.mode == amd_pkg::AMD_M_BIT_IR) begin
          rel_nxt = ext_r[7:0];
        end
      end
    endcase
  end

  // ------------------------
  // State registers
  // ------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= AMD_S_OPC;
      pre_r <= '0;
      pre_v_r <= 1'b0;
      opc_r <= '0;
      left_r <= '0;
      ext_r <= '0;
      ptr_r <= '0;
      pc_r <= '0;
      ea_valid <= 1'b0;
      ea_addr <= '0;
      imm_operand <= '0;
      rel_offset <= '0;
      dec_out <= '0;
      wait_enter <= 1'b0;
      halt_enter <= 1'b0;
      trap_raise <= 1'b0;
      illegal_op <= 1'b0;
      ptr_req <= '0;
    end else begin
      state_r <= state_nxt;
      pre_r <= pre_nxt;
      pre_v_r <= pre_v_nxt;
      opc_r <= opc_nxt;
      left_r <= left_nxt;
      ext_r <= ext_nxt;
      ptr_r <= ptr_nxt;
      pc_r <= pc_nxt;
      ea_valid <= ea_valid_nxt;
      ea_addr <= ea_nxt;
      imm_operand <= imm_nxt;
      rel_offset <= rel_nxt;
      dec_out <= dec_nxt;
      wait_enter <= wait_nxt;
      halt_enter <= halt_nxt;
      trap_raise <= trap_nxt;
      illegal_op <= ill_nxt;
      ptr_req <= ptr_req_nxt;
    end
  end

endmodule

// *** bench/amd_decoder_monitor.sv ***
`timescale 1ns/1ps
module amd_decoder_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Watched ports
  input wire logic fetch_ready,
  input wire amd_pkg::amd_mem_req_t ptr_req,
  input wire logic ptr_ack,
  input wire logic ea_valid,
  input wire logic [15:0] ea_addr,
  input wire amd_pkg::amd_decode_t dec_out,
  input wire logic wait_enter,
  input wire logic halt_enter,
  input wire logic trap_raise
);
  logic side;
  amd_pkg::amd_mode_t md;
  assign side = wait_enter | halt_enter | trap_raise;
  assign md = dec_out.mode;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // -----------------------------------------------------------
  // Result checks, on the result pulse and on each side pulse
  // -----------------------------------------------------------
  side_with_ea_a: assert property (side |-> ea_valid)
    else $error("side pulse without a result");
  side_onehot_a: assert property (ea_valid |-> $onehot0({wait_enter, halt_enter, trap_raise}))
    else $error("more than one side pulse");
  side_pulse_a: assert property (side |=> !side || ea_valid)
    else $error("side pulse longer than one cycle");
  inh_len_a: assert property (ea_valid && dec_out.group == amd_pkg::AMD_GRP_INHERENT
    |-> dec_out.ext_bytes == amd_pkg::AMD_EXT_0) else $error("inherent with extension");
  imm_len_a: assert property (ea_valid && dec_out.group == amd_pkg::AMD_GRP_IMMEDIATE
    |-> dec_out.ext_bytes == amd_pkg::AMD_EXT_1) else $error("immediate length wrong");
  long_len_a: assert property (ea_valid && md inside {amd_pkg::AMD_M_DIR_L,
    amd_pkg::AMD_M_IDX_L} |-> dec_out.ext_bytes == amd_pkg::AMD_EXT_2)
    else $error("long form length wrong");
  short_dir_a: assert property (ea_valid && md == amd_pkg::AMD_M_DIR_S
    |-> dec_out.is_short && dec_out.ext_bytes == amd_pkg::AMD_EXT_1)
    else $error("short direct not short");
  short_page_a: assert property (ea_valid && md inside {amd_pkg::AMD_M_DIR_S,
    amd_pkg::AMD_M_IND_S, amd_pkg::AMD_M_IDX_0} |-> ea_addr[15:8] == 8'h00)
    else $error("short address left page zero");
  idx_short_a: assert property (ea_valid && md == amd_pkg::AMD_M_IDX_S
    |-> ea_addr <= 16'h01FE) else $error("short indexed beyond 1FE");
  // -----------------------------------------------------------
  // Pointer reads
  // -----------------------------------------------------------
  ptr_hold_a: assert property (ptr_req.valid && !ptr_ack
    |=> ptr_req.valid && $stable(ptr_req.addr)) else $error("pointer request dropped");
  ptr_refuse_a: assert property (ptr_req.valid |-> !fetch_ready)
    else $error("fetch accepted during pointer read");

  cover property (ea_valid && dec_out.group == amd_pkg::AMD_GRP_INDIRECT);
  cover property (ea_valid && dec_out.group == amd_pkg::AMD_GRP_RELATIVE);
  cover property (trap_raise);
  cover property (ptr_req.valid && ptr_ack);
endmodule

bind amd_decoder amd_decoder_monitor amd_decoder_monitor_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .fetch_ready(fetch_ready),
  .ptr_req(ptr_req), .ptr_ack(ptr_ack), .ea_valid(ea_valid), .ea_addr(ea_addr),
  .dec_out(dec_out), .wait_enter(wait_enter), .halt_enter(halt_enter),
  .trap_raise(trap_raise)
);

// *** bench/amd_mem_model.sv ***
`timescale 1ns/1ps
module amd_mem_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Pointer read port
  input wire amd_pkg::amd_mem_req_t ptr_req,
  input wire logic slow,
  output logic ptr_ack,
  output logic [7:0] ptr_data
);
  logic [7:0] mem [512];
  logic [3:0] cnt;
  logic busy;
  logic [8:0] a;

  // Skip the ack edge: the request seen there is still the old one
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_ack <= 1'b0;
      ptr_data <= 8'h00;
      busy <= 1'b0;
      cnt <= 4'h0;
      a <= 9'h000;
    end else if (ptr_ack) begin
      ptr_ack <= 1'b0;
      ptr_data <= ~ptr_data;
    end else if (busy) begin
      if (cnt == 4'h0) begin
        ptr_ack <= 1'b1;
        ptr_data <= mem[a];
        busy <= 1'b0;
      end else begin
        cnt <= cnt - 4'h1;
      end
    end else if (ptr_req.valid) begin
      busy <= 1'b1;
      a <= ptr_req.addr[8:0];
      cnt <= slow ? 4'h5 : 4'h0;
    end
  end
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic sys_clk, reset_n, fetch_valid, fetch_ready, ptr_ack, slow;
  logic [7:0] fetch_byte, index_x, index_y, ptr_data, imm_operand, rel_offset;
  logic [15:0] pc_in, ea_addr;
  logic ea_valid, wait_enter, halt_enter, trap_raise, illegal_op;
  amd_pkg::amd_mem_req_t ptr_req;
  amd_pkg::amd_decode_t dec_out;
  logic [7:0] s, r, h, p, v, w;
  int fails, samples_checked;

  amd_decoder amd_decoder_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .fetch_ready(fetch_ready),
    .pc_in(pc_in), .index_x(index_x), .index_y(index_y), .ptr_req(ptr_req),
    .ptr_ack(ptr_ack), .ptr_data(ptr_data), .ea_valid(ea_valid), .ea_addr(ea_addr),
    .imm_operand(imm_operand), .rel_offset(rel_offset), .dec_out(dec_out),
    .wait_enter(wait_enter), .halt_enter(halt_enter), .trap_raise(trap_raise),
    .illegal_op(illegal_op));
  amd_mem_model amd_mem_model_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .ptr_req(ptr_req), .slow(slow), .ptr_ack(ptr_ack), .ptr_data(ptr_data));

  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] q);
    return {q[6:0], q[7] ^ q[5] ^ q[4] ^ q[3]};
  endfunction

  function automatic logic [15:0] branch_to(input logic [15:0] pc, input logic [7:0] off);
    return pc + {{8{off[7]}}, off};
  endfunction

  task automatic rnd(output logic [7:0] o);
    s = lfsr(s);
    o = s;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Bytes go out high byte first; holds each until ready is seen
  task automatic op(input int n, input logic [31:0] b);
    int k;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      fetch_valid = 1'b1;
      fetch_byte = b[31-8*i -: 8];
      k = 0;
      while (fetch_ready !== 1'b1 && k < 50) begin
        @(negedge sys_clk);
        k++;
      end
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    fetch_valid = 1'b0;
    fetch_byte = ~fetch_byte;
    k = 0;
    while (ea_valid !== 1'b1 && k < 60) begin
      @(negedge sys_clk);
      k++;
    end
    chk("result pulse", 16'h1, {15'h0, ea_valid});
  endtask

  task automatic grp(input logic [2:0] g, input logic [1:0] e);
    chk("group", 16'(g), 16'(dec_out.group));
    chk("ext bytes", 16'(e), 16'(dec_out.ext_bytes));
  endtask

  // ---------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------
  initial begin
    fails = 0;
    samples_checked = 0;
    s = 8'h4F;
    reset_n = 1'b0;
    fetch_valid = 1'b0;
    fetch_byte = 8'h00;
    pc_in = 16'h0000;
    index_x = 8'h00;
    index_y = 8'h00;
    slow = 1'b0;
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    for (int it = 0; it < 8; it++) begin
      rnd(r);
      rnd(h);
      rnd(v);
      rnd(w);
      rnd(p);
      rnd(index_x);
      rnd(index_y);
      p[7] = 1'b0;
      slow = s[0];
      pc_in = {w, v};
      if (it == 0) begin
        index_x = 8'hFF;
        r = 8'hFF;
        h = 8'hFF;
      end
      if (it == 1) begin
        r = 8'h80;
        index_x = 8'h00;
      end
      amd_mem_model_i.mem[{1'b0, p}] = v;
      amd_mem_model_i.mem[{1'b0, p} + 9'h001] = w;
      op(1, {amd_pkg::AMD_OP_TRAP, 24'h0}); grp(3'h0, 2'h0);
      chk("trap", 16'h1, {15'h0, trap_raise});
      op(1, {amd_pkg::AMD_OP_WAIT, 24'h0}); grp(3'h0, 2'h0);
      chk("wait", 16'h1, {15'h0, wait_enter});
      op(1, {amd_pkg::AMD_OP_HALT, 24'h0});
      chk("halt", 16'h1, {15'h0, halt_enter});
      @(negedge sys_clk);
      fetch_valid = 1'b1;
      fetch_byte = 8'hAD;
      @(negedge sys_clk);
      fetch_valid = 1'b0;
      chk("illegal imm", 16'h1, {15'h0, illegal_op});
      op(2, {8'hA6, r, 16'h0}); grp(3'h1, 2'h1);
      chk("imm", {8'h00, r}, {8'h00, imm_operand});
      op(2, {8'hB6, r, 16'h0}); grp(3'h2, 2'h1);
      chk("short direct", {8'h00, r}, ea_addr);
      op(3, {8'hC6, h, r, 8'h0}); grp(3'h2, 2'h2);
      chk("long direct", {h, r}, ea_addr);
      op(1, {8'hF6, 24'h0}); grp(3'h3, 2'h0);
      chk("x no offset", {8'h00, index_x}, ea_addr);
      op(2, {amd_pkg::AMD_PRE_Y, 8'hF6, 16'h0}); grp(3'h3, 2'h1);
      chk("y no offset", {8'h00, index_y}, ea_addr);
      op(2, {8'hE6, r, 16'h0});
      chk("short indexed", 16'(index_x) + 16'(r), ea_addr);
      op(3, {8'hD6, h, r, 8'h0});
      chk("long indexed", {h, r} + 16'(index_x), ea_addr);
      op(3, {amd_pkg::AMD_PRE_IX, 8'hB6, p, 8'h0}); grp(3'h4, 2'h2);
      chk("short indirect", {8'h00, v}, ea_addr);
      op(3, {amd_pkg::AMD_PRE_IX, 8'hC6, p, 8'h0}); grp(3'h4, 2'h2);
      chk("long indirect", {v, w}, ea_addr);
      op(2, {8'h27, r, 16'h0}); grp(3'h5, 2'h1);
      chk("branch target", branch_to(pc_in, r), ea_addr);
      chk("rel offset", {8'h00, r}, {8'h00, rel_offset});
      op(2, {8'h10, r, 16'h0}); grp(3'h6, 2'h1);
      chk("bit direct", {8'h00, r}, ea_addr);
      op(3, {8'h00, r, h, 8'h0});
      grp(3'h6, 2'h2);
      chk("bit address", {8'h00, r}, ea_addr);
      chk("bit offset", {8'h00, h}, {8'h00, rel_offset});
      op(4, {amd_pkg::AMD_PRE_IX, 8'h00, p, h});
      chk("bit indirect", {8'h00, v}, ea_addr);
    end
    tally_and_finish();
  end

  initial begin
    #80000;
    fails++;
    $display("[FAIL] watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule
